/* otrr_host.sv */
`timescale 1ns/1ps
module otrr_host (
  input  wire logic        clock,              // System clock
  input  wire logic        cmd_rvalid,         // Read valid
  input  wire logic [15:0] cmd_rdata,          // Read data
  output logic             cmd_wr = 1'b0,      // Write strobe
  output logic             cmd_rd = 1'b0,      // Read strobe
  output logic      [7:0]  cmd_code = 8'h00,   // Command code
  output logic      [15:0] cmd_wdata = 16'h0000 // Write data
);
  // One write, released after the taking edge
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clock);
    cmd_wr    <= 1'b1;
    cmd_code  <= code;
    cmd_wdata <= data;
    @(posedge clock);
    cmd_wr    <= 1'b0;
    cmd_code  <= ~code;
    cmd_wdata <= ~data;
  endtask
  // One read, data taken with the valid pulse
  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    logic got;
    got  = 1'b0;
    data = 16'h0000;
    @(posedge clock);
    cmd_rd   <= 1'b1;
    cmd_code <= code;
    @(posedge clock);
    cmd_rd   <= 1'b0;
    cmd_code <= ~code;
    for (int i = 0; i < 4 && !got; i++) begin
      @(posedge clock);
      got  = (cmd_rvalid === 1'b1);
      data = got ? cmd_rdata : 16'hDEAD;
    end
  endtask
endmodule

/* otrr_pacer.sv */
`timescale 1ns/1ps
module otrr_pacer
  import otrr_pkg::*;
#(
  parameter int unsigned DIV = 4  // Cycles per tick
) (
  input  wire logic clock,  // System clock
  input  wire logic arst_n, // Async reset, active low
  input  wire logic ce,     // Clock enable
  output logic      tick    // One-cycle pulse every DIV cycles
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count_reg;  // Cycle counter
  logic [CW-1:0] count_next;
  logic          tick_reg;   // Registered tick
  logic          tick_next;

  // Next count and tick
  always_comb begin
    count_next = count_reg;
    tick_next  = 1'b0;
    if (count_reg == LAST) begin
      count_next = '0;
      tick_next  = 1'b1;
    end else begin
      count_next = count_reg + 1'b1;
    end
  end

  // Register, frozen while ce is low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else if (ce) begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick = tick_reg & ce;

endmodule

/* otrr_pkg.sv */
package otrr_pkg;

  // Command codes of the configuration words
  localparam logic [7:0] OTRR_CMD_NORMAL_ON_TIME  = 8'h1E;
  localparam logic [7:0] OTRR_CMD_SOFT_START_ON   = 8'h1F;
  localparam logic [7:0] OTRR_CMD_REFERENCE_SLEW  = 8'h21;
  localparam logic [7:0] OTRR_CMD_OUTPUT_TRIM     = 8'h22;

  // Field positions
  localparam int OTRR_NORMAL_MSB    = 9;   // Normal on-time field
  localparam int OTRR_SS_INIT_MSB   = 13;  // Soft-start initial on-time field
  localparam int OTRR_SS_INIT_LSB   = 8;
  localparam int OTRR_SLEW_SEL_BIT  = 15;  // Ramp timebase select
  localparam int OTRR_STEP_MSB      = 14;  // Step interval count
  localparam int OTRR_STEP_LSB      = 8;
  localparam int OTRR_TARGET_MSB    = 7;   // Reference target code
  localparam int OTRR_TRIM_MSB      = 3;   // Trim field

  // Reset values
  localparam logic [9:0]  OTRR_RST_NORMAL     = 10'h000;
  localparam logic [15:0] OTRR_RST_SOFT_START = 16'h0000;
  localparam logic [15:0] OTRR_RST_SLEW       = 16'h0000;
  localparam logic [3:0]  OTRR_RST_TRIM       = 4'h0;

  // Timing, in picoseconds, and derived cycle counts
  localparam int OTRR_CLK_PERIOD_PS = 25000;
  localparam int OTRR_TB_FAST_PS    = 100000;
  localparam int OTRR_TB_SLOW_PS    = 1000000;
  localparam int OTRR_TB_FAST_CYC   = OTRR_TB_FAST_PS / OTRR_CLK_PERIOD_PS;
  localparam int OTRR_TB_SLOW_CYC   = OTRR_TB_SLOW_PS / OTRR_CLK_PERIOD_PS;

  // Soft-start sequencer states
  typedef enum logic [1:0] {
    OTRR_SS_IDLE,
    OTRR_SS_RAMP,
    OTRR_SS_DONE
  } otrr_ss_state_t;

endpackage

/* otrr_properties.sv */
`timescale 1ns/1ps
module otrr_properties
  import otrr_pkg::*;
(
  input wire logic               clock,                       // System clock
  input wire logic               arst_n,                      // Reset, active low
  input wire logic               ce,                          // Clock enable
  input wire logic               cmd_wr,                      // Write strobe
  input wire logic               cmd_rd,                      // Read strobe
  input wire logic        [7:0]  cmd_code,                    // Command code
  input wire logic        [15:0] cmd_wdata,                   // Write data
  input wire logic               cmd_rvalid,                  // Read valid
  input wire logic               cmd_known,                   // Code mapped
  input wire logic               open_loop,                   // Open loop
  input wire logic        [9:0]  output_sense_input,          // Sense sample
  input wire logic               sense_valid,                 // Sample strobe
  input wire logic        [9:0]  ontime_code,                 // On-time code
  input wire logic               soft_start_active,           // Ramping
  input wire logic               soft_start_done,             // Ramp complete
  input wire logic        [7:0]  voltage_reference_code,      // Reference
  input wire logic        [7:0]  overvoltage_threshold_base,  // OV base
  input wire logic        [7:0]  undervoltage_threshold_base, // UV base
  input wire logic        [7:0]  loop_setpoint,               // Setpoint
  input wire logic signed [11:0] loop_error,                  // Loop error
  input wire logic               loop_error_valid             // Error strobe
);
  logic [9:0]  norm_q;  // Mirror of normal on-time
  logic [5:0]  init_q;  // Mirror of initial on-time
  logic [7:0]  tgt_q;   // Mirror of target code
  logic [3:0]  trim_q;  // Mirror of trim
  logic [11:0] err_exp; // Expected loop error
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Mirror the configuration words
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      norm_q <= 10'h000;
      init_q <= 6'h00;
      tgt_q  <= 8'h00;
      trim_q <= 4'h0;
    end else if (ce && cmd_wr) begin
      if (cmd_code == 8'h1E) norm_q <= cmd_wdata[9:0];
      if (cmd_code == 8'h1F) init_q <= cmd_wdata[13:8];
      if (cmd_code == 8'h21) tgt_q <= cmd_wdata[7:0];
      if (cmd_code == 8'h22) trim_q <= cmd_wdata[3:0];
    end
  end
  // Error expected from mirrored fields
  assign err_exp = {2'h0, tgt_q, 2'h0} + {8'h00, trim_q} - {2'h0, output_sense_input};
  AST_RVALID: assert property (ce && cmd_rd |=> cmd_rvalid)
    else $error("read strobe not answered");
  AST_KNOWN: assert property (cmd_known == (cmd_code inside {8'h1E, 8'h1F, 8'h21, 8'h22}))
    else $error("mapped flag wrong");
  AST_REF_SHARED: assert property (loop_setpoint == voltage_reference_code &&
    overvoltage_threshold_base == voltage_reference_code &&
    undervoltage_threshold_base == voltage_reference_code)
    else $error("reference copies differ");
  AST_REF_STEP: assert property ($changed(voltage_reference_code) |->
    (voltage_reference_code - $past(voltage_reference_code) == 8'h01) ||
    ($past(voltage_reference_code) - voltage_reference_code == 8'h01))
    else $error("reference moved more than one code");
  AST_REF_HOLD: assert property (voltage_reference_code == tgt_q &&
    !(ce && cmd_wr && cmd_code == 8'h21) |=> $stable(voltage_reference_code))
    else $error("reference left its target");
  AST_ERR: assert property (ce && sense_valid |=> loop_error_valid &&
    loop_error == $past(err_exp))
    else $error("loop error wrong");
  AST_OPEN_LOOP: assert property (open_loop |-> ontime_code == norm_q)
    else $error("open loop on-time wrong");
  AST_SS_START: assert property ($rose(soft_start_active) && !open_loop |->
    ontime_code == {4'h0, init_q})
    else $error("soft start began at wrong on-time");
  AST_SS_UP: assert property (soft_start_active && $past(soft_start_active) &&
    !open_loop && !$past(open_loop) |-> ontime_code >= $past(ontime_code))
    else $error("soft start on-time fell");
  AST_SS_DONE: assert property (soft_start_done |-> ontime_code == norm_q)
    else $error("completed on-time wrong");
endmodule

/* otrr_top.sv */
`timescale 1ns/1ps
// Function
// - Normal on-time is (field+1) times 5 ns
// - Normal on-time ends soft start, open loop
// - Soft-start start from bits 13:8 only
// - Soft start begins at (field+1) times 5 ns
// - Soft-start reserved bits stored, no effect
// - Normal 15:10, trim 7:4 read-only undefined
// - Bit 15 selects 1 us or 0.1 us
// - One reference step per count times timebase, one per tick for count 0
// - Target code is 6.25 mV per LSB
// - Ramped reference feeds setpoint and thresholds
// - Error is target*4 plus trim minus sense
// - Sense sample is 10-bit conversion result
// - Trim adds 1.5625 mV per step
// - Soft start ramps up to normal on-time
module otrr_top
  import otrr_pkg::*;
(
  input  wire logic        clock,                       // 40 MHz system clock
  input  wire logic        arst_n,                      // Async reset, active low
  input  wire logic        ce,                          // Clock enable
  input  wire logic        cmd_wr,                      // Command write strobe
  input  wire logic        cmd_rd,                      // Command read strobe
  input  wire logic [7:0]  cmd_code,                    // Command code
  input  wire logic [15:0] cmd_wdata,                   // Write data word
  output logic      [15:0] cmd_rdata,                   // Read data word
  output logic             cmd_rvalid,                  // Read data valid pulse
  output logic             cmd_known,                   // Code is mapped
  input  wire logic        run_enable,                  // Converter running request
  input  wire logic        open_loop,                   // Open-loop operation
  input  wire logic [9:0]  output_sense_input,          // Sense conversion result
  input  wire logic        sense_valid,                 // New sense sample
  output logic      [9:0]  ontime_code,                 // Active on-time code, 5 ns units
  output logic             soft_start_active,           // Soft start ramping
  output logic             soft_start_done,             // Soft start complete
  output logic      [7:0]  voltage_reference_code,      // Ramped reference code
  output logic      [7:0]  overvoltage_threshold_base,  // OV threshold base
  output logic      [7:0]  undervoltage_threshold_base, // UV threshold base
  output logic      [7:0]  loop_setpoint,               // Closed-loop setpoint
  output logic signed [11:0] loop_error,                // DC loop error
  output logic             loop_error_valid             // Error updated pulse
);

  // Configuration storage
  logic [9:0]  normal_on_time_reg;      // Normal on-time field
  logic [9:0]  normal_on_time_next;
  logic [15:0] soft_start_on_time_reg;  // Whole soft-start word
  logic [15:0] soft_start_on_time_next;
  logic [15:0] reference_slew_reg;      // Whole slew control word
  logic [15:0] reference_slew_next;
  logic [3:0]  output_trim_reg;         // Trim field
  logic [3:0]  output_trim_next;
  logic [15:0] rdata_reg;               // Read data
  logic [15:0] rdata_next;
  logic        rvalid_reg;              // Read valid
  logic        rvalid_next;

  // Decoded fields
  logic [5:0]  soft_start_initial_on_time;  // Starting on-time
  logic        timebase_slow;               // Ramp timebase select
  logic [6:0]  reference_step_interval;     // Ticks per step
  logic [7:0]  reference_target_code;       // Target code

  // Timebase ticks
  logic tick_fast;  // 0.1 us
  logic tick_slow;  // 1 us
  logic tick_ref;   // Selected ramp timebase

  // Reference ramp state
  logic [7:0] ref_code_reg;   // Ramped reference
  logic [7:0] ref_code_next;
  logic [6:0] step_cnt_reg;   // Timebase ticks since last step
  logic [6:0] step_cnt_next;

  // Soft-start state
  otrr_ss_state_t ss_state_reg;   // Sequencer state
  otrr_ss_state_t ss_state_next;
  logic [9:0]     ss_ontime_reg;  // Ramping on-time
  logic [9:0]     ss_ontime_next;

  // Loop error state
  logic signed [11:0] err_reg;    // Registered error
  logic signed [11:0] err_next;
  logic               errv_reg;   // Error valid
  logic               errv_next;

  // Field extraction
  // initial on-time field
  assign soft_start_initial_on_time =
    soft_start_on_time_reg[OTRR_SS_INIT_MSB:OTRR_SS_INIT_LSB];
  assign timebase_slow           = reference_slew_reg[OTRR_SLEW_SEL_BIT];
  assign reference_step_interval = reference_slew_reg[OTRR_STEP_MSB:OTRR_STEP_LSB];
  assign reference_target_code   = reference_slew_reg[OTRR_TARGET_MSB:0];

  // Command decode
  always_comb begin
    cmd_known = 1'b1;
    case (cmd_code)
      OTRR_CMD_NORMAL_ON_TIME: cmd_known = 1'b1;
      OTRR_CMD_SOFT_START_ON:  cmd_known = 1'b1;
      OTRR_CMD_REFERENCE_SLEW: cmd_known = 1'b1;
      OTRR_CMD_OUTPUT_TRIM:    cmd_known = 1'b1;
      default:                 cmd_known = 1'b0;
    endcase
  end

  // Register writes and reads, next values
  always_comb begin
    normal_on_time_next     = normal_on_time_reg;
    soft_start_on_time_next = soft_start_on_time_reg;
    reference_slew_next     = reference_slew_reg;
    output_trim_next        = output_trim_reg;
    rdata_next              = rdata_reg;
    rvalid_next             = 1'b0;
    if (cmd_wr) begin
      case (cmd_code)
        OTRR_CMD_NORMAL_ON_TIME: begin
          normal_on_time_next = cmd_wdata[OTRR_NORMAL_MSB:0];
        end
        OTRR_CMD_SOFT_START_ON: begin
          soft_start_on_time_next = cmd_wdata;
        end
        OTRR_CMD_REFERENCE_SLEW: begin
          reference_slew_next = cmd_wdata;
        end
        OTRR_CMD_OUTPUT_TRIM: begin
          output_trim_next = cmd_wdata[OTRR_TRIM_MSB:0];
        end
        default: begin
          // Unmapped write ignored
        end
      endcase
    end
    if (cmd_rd) begin
      rvalid_next = 1'b1;
      case (cmd_code)
        OTRR_CMD_NORMAL_ON_TIME: rdata_next = {6'h00, normal_on_time_reg};
        OTRR_CMD_SOFT_START_ON:  rdata_next = soft_start_on_time_reg;
        OTRR_CMD_REFERENCE_SLEW: rdata_next = reference_slew_reg;
        OTRR_CMD_OUTPUT_TRIM:    rdata_next = {12'h000, output_trim_reg};
        default:                 rdata_next = 16'h0000;
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      normal_on_time_reg     <= OTRR_RST_NORMAL;
      soft_start_on_time_reg <= OTRR_RST_SOFT_START;
      reference_slew_reg     <= OTRR_RST_SLEW;
      output_trim_reg        <= OTRR_RST_TRIM;
      rdata_reg              <= 16'h0000;
      rvalid_reg             <= 1'b0;
    end else if (ce) begin
      normal_on_time_reg     <= normal_on_time_next;
      soft_start_on_time_reg <= soft_start_on_time_next;
      reference_slew_reg     <= reference_slew_next;
      output_trim_reg        <= output_trim_next;
      rdata_reg              <= rdata_next;
      rvalid_reg             <= rvalid_next;
    end
  end

  assign cmd_rdata  = rdata_reg;
  assign cmd_rvalid = rvalid_reg;

  // Timebase generators
  otrr_pacer #(.DIV(OTRR_TB_FAST_CYC)) u_pace_fast (
    .clock  (clock),
    .arst_n (arst_n),
    .ce     (ce),
    .tick   (tick_fast)
  );

  otrr_pacer #(.DIV(OTRR_TB_SLOW_CYC)) u_pace_slow (
    .clock  (clock),
    .arst_n (arst_n),
    .ce     (ce),
    .tick   (tick_slow)
  );

  assign tick_ref = timebase_slow ? tick_slow : tick_fast;

  // Reference ramp, next values
  always_comb begin
    ref_code_next = ref_code_reg;
    step_cnt_next = step_cnt_reg;
    if (ref_code_reg == reference_target_code) begin
      step_cnt_next = 7'h00;
    end else if (tick_ref) begin
      if (step_cnt_reg + 7'h01 >= reference_step_interval) begin
        step_cnt_next = 7'h00;
        if (ref_code_reg < reference_target_code) begin
          ref_code_next = ref_code_reg + 8'h01;
        end else begin
          ref_code_next = ref_code_reg - 8'h01;
        end
      end else begin
        step_cnt_next = step_cnt_reg + 7'h01;
      end
    end
  end

  // Reference ramp storage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ref_code_reg <= 8'h00;
      step_cnt_reg <= 7'h00;
    end else if (ce) begin
      ref_code_reg <= ref_code_next;
      step_cnt_reg <= step_cnt_next;
    end
  end

  // ramped reference to loop and thresholds
  assign voltage_reference_code      = ref_code_reg;
  assign loop_setpoint               = ref_code_reg;
  assign overvoltage_threshold_base  = ref_code_reg;
  assign undervoltage_threshold_base = ref_code_reg;

  // Soft-start sequencer, next values
  always_comb begin
    ss_state_next  = ss_state_reg;
    ss_ontime_next = ss_ontime_reg;
    case (ss_state_reg)
      OTRR_SS_IDLE: begin
        ss_ontime_next = {4'h0, soft_start_initial_on_time};
        if (run_enable && !open_loop) begin
          ss_state_next = OTRR_SS_RAMP;
        end
      end
      OTRR_SS_RAMP: begin
        if (!run_enable) begin
          ss_state_next = OTRR_SS_IDLE;
        end else if (ss_ontime_reg >= normal_on_time_reg) begin
          ss_ontime_next = normal_on_time_reg;
          ss_state_next  = OTRR_SS_DONE;
        end else if (tick_fast) begin
          ss_ontime_next = ss_ontime_reg + 10'h001;
        end
      end
      OTRR_SS_DONE: begin
        ss_ontime_next = normal_on_time_reg;
        if (!run_enable) begin
          ss_state_next = OTRR_SS_IDLE;
        end
      end
      default: begin
        ss_state_next = OTRR_SS_IDLE;
      end
    endcase
  end

  // Soft-start storage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ss_state_reg  <= OTRR_SS_IDLE;
      ss_ontime_reg <= 10'h000;
    end else if (ce) begin
      ss_state_reg  <= ss_state_next;
      ss_ontime_reg <= ss_ontime_next;
    end
  end

  // Active on-time selection
  always_comb begin
    if (open_loop) begin
      ontime_code = normal_on_time_reg;
    end else if (ss_state_reg == OTRR_SS_RAMP) begin
      // initial field only in soft start
      ontime_code = ss_ontime_reg;
    end else begin
      ontime_code = normal_on_time_reg;
    end
  end

  assign soft_start_active = (ss_state_reg == OTRR_SS_RAMP);
  assign soft_start_done   = (ss_state_reg == OTRR_SS_DONE);

  // Loop error, next values
  always_comb begin
    err_next  = err_reg;
    errv_next = 1'b0;
    if (sense_valid) begin
      err_next = $signed({2'b00, reference_target_code, 2'b00})
               + $signed({8'h00, output_trim_reg})
               - $signed({2'b00, output_sense_input});
      errv_next = 1'b1;
    end
  end

  // Loop error storage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      err_reg  <= 12'sh000;
      errv_reg <= 1'b0;
    end else if (ce) begin
      err_reg  <= err_next;
      errv_reg <= errv_next;
    end
  end

  assign loop_error       = err_reg;
  assign loop_error_valid = errv_reg;

endmodule

/* tb_otrr_top.sv */
`timescale 1ns/1ps
module tb_otrr_top
  import otrr_pkg::*;
;
  logic               clock = 1'b0;               // System clock
  logic               arst_n = 1'b0;              // Reset, active low
  logic               ce = 1'b1;                  // Enable, high except for 40 cycles in the freeze test
  logic               run_enable = 1'b0;          // Run request
  logic               open_loop = 1'b0;           // Open loop
  logic        [9:0]  output_sense_input = 10'h0; // Sense sample
  logic               sense_valid = 1'b0;         // Sample strobe
  logic               cmd_wr, cmd_rd, cmd_rvalid, cmd_known;
  logic        [7:0]  cmd_code;
  logic        [15:0] cmd_wdata, cmd_rdata, d;
  logic        [9:0]  ontime_code;
  logic               soft_start_active, soft_start_done, loop_error_valid;
  logic        [7:0]  voltage_reference_code, loop_setpoint;
  logic        [7:0]  overvoltage_threshold_base, undervoltage_threshold_base;
  logic signed [11:0] loop_error;
  int                 err_count = 0;              // Mismatches
  int                 checked = 0;                // Comparisons
  int                 cyc = 0;                    // Cycle count
  int                 n;                          // Measured gap
  // Code, written word, read-back word
  logic [39:0] acc [4] = '{40'h1E_FFFF_03FF, 40'h22_FFFF_000F,
                           40'h1F_CAFF_CAFF, 40'h30_FFFF_0000};
  // Sense sample and expected error
  logic [25:0] err_t [3] = '{{10'h020, 16'h0FFB}, {10'h000, 16'h001B}, {10'h3FF, 16'h0C1C}};
  otrr_host u_host (.clock, .cmd_rvalid, .cmd_rdata, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata);
  otrr_top u_dut (.clock, .arst_n, .ce, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata,
    .cmd_rvalid, .cmd_known, .run_enable, .open_loop, .output_sense_input, .sense_valid,
    .ontime_code, .soft_start_active, .soft_start_done, .voltage_reference_code,
    .overvoltage_threshold_base, .undervoltage_threshold_base, .loop_setpoint,
    .loop_error, .loop_error_valid);
  // Clock generation, 25 ns period
  initial begin
    forever #12.5 clock = ~clock;
  end
  // Cycle counter and hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Cycles between two reference moves
  task automatic gap(output int g);
    logic [7:0] v;
    int         c0;
    v = voltage_reference_code;
    for (int i = 0; i < 400 && voltage_reference_code === v; i++) @(posedge clock);
    v  = voltage_reference_code;
    c0 = cyc;
    for (int i = 0; i < 400 && voltage_reference_code === v; i++) @(posedge clock);
    g = cyc - c0;
  endtask
  // Bounded wait on a reference value
  task automatic wait_ref(input logic [7:0] v);
    for (int i = 0; i < 400 && voltage_reference_code !== v; i++) @(posedge clock);
  endtask
  // Counts, verdict, stop
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    // Reset value, then stored bits
    foreach (acc[i]) begin
      u_host.rd(acc[i][39:32], d);
      chk(d, 16'h0000);
      u_host.wr(acc[i][39:32], acc[i][31:16]);
      u_host.rd(acc[i][39:32], d);
      chk(d, acc[i][15:0]);
    end
    $display("test registers done");
    // Fast then slow ramp
    u_host.wr(OTRR_CMD_REFERENCE_SLEW, 16'h0205);
    gap(n);
    chk(16'(n), 16'h0008);
    wait_ref(8'h05);
    chk({8'h00, voltage_reference_code}, 16'h0005);
    u_host.wr(OTRR_CMD_REFERENCE_SLEW, 16'h8103);
    gap(n);
    chk(16'(n), 16'h0028);
    wait_ref(8'h03);
    repeat (100) @(posedge clock);
    chk({8'h00, voltage_reference_code}, 16'h0003);
    chk({8'h00, loop_setpoint}, 16'h0003);
    chk({8'h00, overvoltage_threshold_base}, 16'h0003);
    $display("test ramp done");
    // Errors with trim F and target 3
    foreach (err_t[i]) begin
      @(posedge clock);
      output_sense_input <= err_t[i][25:16];
      sense_valid        <= 1'b1;
      @(posedge clock);
      output_sense_input <= ~err_t[i][25:16];
      sense_valid        <= 1'b0;
      @(posedge clock);
      chk({15'h0, loop_error_valid}, 16'h0001);
      chk({4'h0, loop_error}, err_t[i][15:0]);
    end
    $display("test error done");
    // Frozen while ce is low, then a zero count steps on every tick
    u_host.wr(OTRR_CMD_REFERENCE_SLEW, 16'h0005);
    ce <= 1'b0;
    repeat (40) @(posedge clock);
    chk({8'h00, voltage_reference_code}, 16'h0003);
    ce <= 1'b1;
    gap(n);
    chk(16'(n), 16'h0004);
    chk({8'h00, undervoltage_threshold_base}, 16'h0005);
    $display("test freeze done");
    // Soft start from 0A up to 10
    u_host.wr(OTRR_CMD_NORMAL_ON_TIME, 16'h0010);
    run_enable <= 1'b1;
    for (int i = 0; i < 10 && soft_start_active !== 1'b1; i++) @(posedge clock);
    chk({6'h0, ontime_code}, 16'h000A);
    chk({15'h0, soft_start_active}, 16'h0001);
    for (int i = 0; i < 200 && soft_start_done !== 1'b1; i++) @(posedge clock);
    chk({6'h0, ontime_code}, 16'h0010);
    chk({15'h0, soft_start_done}, 16'h0001);
    open_loop  <= 1'b1;
    run_enable <= 1'b0;
    repeat (3) @(posedge clock);
    chk({6'h0, ontime_code}, 16'h0010);
    chk({14'h0, soft_start_active, soft_start_done}, 16'h0000);
    open_loop <= 1'b0;
    $display("test soft start done");
    end_of_test();
  end
endmodule
bind otrr_top otrr_properties u_props (.clock, .arst_n, .ce, .cmd_wr, .cmd_rd, .cmd_code,
  .cmd_wdata, .cmd_rvalid, .cmd_known, .open_loop, .output_sense_input, .sense_valid,
  .ontime_code, .soft_start_active, .soft_start_done, .voltage_reference_code,
  .overvoltage_threshold_base, .undervoltage_threshold_base, .loop_setpoint,
  .loop_error, .loop_error_valid);
